// [common/ebt_regs.svh]
`ifndef EBT_REGS_SVH
`define EBT_REGS_SVH

// Register addresses on the CPU memory port
`define EBT_ADDR_CS0 16'hff6a
`define EBT_ADDR_CS1 16'hff8c
`define EBT_ADDR_CS2 16'hff5b
`define EBT_ADDR_MC0 16'hff6b
`define EBT_ADDR_MC1 16'hff43
`define EBT_ADDR_MC2 16'hff5c

// Field positions
`define EBT_MC_CE_BIT 7
`define EBT_MC_LVS_BIT 3
`define EBT_MC_LVR_BIT 2
`define EBT_MC_INV_BIT 1

// Reset values
`define EBT_CS_RESET 3'h0
`define EBT_MC_RESET 1'h0

// Divider taps, as powers of two of the peripheral clock
`define EBT_PRE_BITS 13
`define EBT_DIV_2 1
`define EBT_DIV_4 2
`define EBT_DIV_16 4
`define EBT_DIV_64 6
`define EBT_DIV_256 8
`define EBT_DIV_4096 12
`define EBT_DIV_8192 13

`endif

// [common/ebt_pkg.sv]
package ebt_pkg;
   typedef enum logic [2:0] {
      EBT_SEL_EXT_FALL = 3'h0,
      EBT_SEL_EXT_RISE = 3'h1,
      EBT_SEL_FULL = 3'h2,
      EBT_SEL_DIV_A = 3'h3,
      EBT_SEL_DIV_B = 3'h4,
      EBT_SEL_DIV_C = 3'h5,
      EBT_SEL_DIV_D = 3'h6,
      EBT_SEL_DIV_E = 3'h7
   } ebt_sel_t;
   typedef logic [7:0] ebt_count_t;
endpackage

// [hw/ebt_timer_ctrl.sv]
`timescale 1ns/1ns
`include "ebt_regs.svh"
module ebt_timer_ctrl
   import ebt_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [15:0] bus_addr,
   input wire logic bus_wr,
   input wire logic [7:0] bus_wr_mask,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic [7:0] cmp0,
   input wire logic [7:0] cmp1,
   input wire logic [7:0] cmp2,
   input wire logic timer_h1_out,
   input wire logic external_count_input,
   input wire logic input_gating_select,
   input wire logic input_gate_level,
   output logic [7:0] count0,
   output logic [7:0] count1,
   output logic [7:0] count2,
   output logic [2:0] match,
   output logic timer0_out
);
   logic rst_meta_q;
   logic rst_q;
   logic [2:0] clock_sel_q [3];
   logic [2:0] count_en_q;
   logic inv_en_q;
   logic out_q;
   logic [`EBT_PRE_BITS-1:0] pre_q;
   logic h1_prev_q;
   logic ext_prev_q;
   ebt_count_t cnt_q [3];
   logic [7:0] cmp [3];
   logic [2:0] tick;
   logic [2:0] cs_hit;
   logic [2:0] mc_hit;
   logic ext_gated;
   logic h1_rise;
   logic ext_fall;
   logic ext_rise;
   logic [7:0] wmasked;
   logic [1:0] lv_wr;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_q <= rst_meta_q;
      end
   end

   assign cs_hit[0] = bus_wr && bus_addr == `EBT_ADDR_CS0;
   assign cs_hit[1] = bus_wr && bus_addr == `EBT_ADDR_CS1;
   assign cs_hit[2] = bus_wr && bus_addr == `EBT_ADDR_CS2;
   assign mc_hit[0] = bus_wr && bus_addr == `EBT_ADDR_MC0;
   assign mc_hit[1] = bus_wr && bus_addr == `EBT_ADDR_MC1;
   assign mc_hit[2] = bus_wr && bus_addr == `EBT_ADDR_MC2;
   assign wmasked = bus_wdata & bus_wr_mask;
   assign lv_wr = mc_hit[0] ? {wmasked[`EBT_MC_LVS_BIT], wmasked[`EBT_MC_LVR_BIT]} : 2'h0;
   assign cmp[0] = cmp0;
   assign cmp[1] = cmp1;
   assign cmp[2] = cmp2;

   // Free-running prescaler; every divided tick is a one-cycle pulse
   always_ff @(posedge clock or negedge rst_q) begin
      if (!rst_q) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // Gate only when the gating select is on; edges need the previous sample
   assign ext_gated = input_gating_select ? (external_count_input & input_gate_level)
                                          : external_count_input;
   always_ff @(posedge clock or negedge rst_q) begin
      if (!rst_q) begin
         h1_prev_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         h1_prev_q <= timer_h1_out;
         ext_prev_q <= ext_gated;
      end
   end
   assign h1_rise = timer_h1_out && !h1_prev_q;
   assign ext_fall = ext_prev_q && !ext_gated;
   assign ext_rise = !ext_prev_q && ext_gated;

   always_comb begin
      tick = 3'h0;
      unique case (ebt_sel_t'(clock_sel_q[0]))
         EBT_SEL_EXT_FALL, EBT_SEL_EXT_RISE: tick[0] = 1'b0;
         EBT_SEL_FULL: tick[0] = 1'b1;
         EBT_SEL_DIV_A: tick[0] = &pre_q[`EBT_DIV_2-1:0];
         EBT_SEL_DIV_B: tick[0] = &pre_q[`EBT_DIV_4-1:0];
         EBT_SEL_DIV_C: tick[0] = &pre_q[`EBT_DIV_64-1:0];
         EBT_SEL_DIV_D: tick[0] = &pre_q[`EBT_DIV_256-1:0];
         EBT_SEL_DIV_E: tick[0] = &pre_q[`EBT_DIV_8192-1:0];
      endcase
      unique case (ebt_sel_t'(clock_sel_q[1]))
         EBT_SEL_EXT_FALL, EBT_SEL_EXT_RISE: tick[1] = 1'b0;
         EBT_SEL_FULL: tick[1] = 1'b1;
         EBT_SEL_DIV_A: tick[1] = &pre_q[`EBT_DIV_2-1:0];
         EBT_SEL_DIV_B: tick[1] = &pre_q[`EBT_DIV_16-1:0];
         EBT_SEL_DIV_C: tick[1] = &pre_q[`EBT_DIV_64-1:0];
         EBT_SEL_DIV_D: tick[1] = &pre_q[`EBT_DIV_256-1:0];
         EBT_SEL_DIV_E: tick[1] = h1_rise;
      endcase
      unique case (ebt_sel_t'(clock_sel_q[2]))
         EBT_SEL_EXT_FALL: tick[2] = ext_fall;
         EBT_SEL_EXT_RISE: tick[2] = ext_rise;
         EBT_SEL_FULL: tick[2] = 1'b1;
         EBT_SEL_DIV_A: tick[2] = &pre_q[`EBT_DIV_2-1:0];
         EBT_SEL_DIV_B: tick[2] = &pre_q[`EBT_DIV_16-1:0];
         EBT_SEL_DIV_C: tick[2] = &pre_q[`EBT_DIV_64-1:0];
         EBT_SEL_DIV_D: tick[2] = &pre_q[`EBT_DIV_256-1:0];
         EBT_SEL_DIV_E: tick[2] = &pre_q[`EBT_DIV_4096-1:0];
      endcase
   end

   // Per-timer registers and counter
   for (genvar i = 0; i < 3; i++) begin : g_tmr
      always_ff @(posedge clock or negedge rst_q) begin
         if (!rst_q) begin
            clock_sel_q[i] <= `EBT_CS_RESET;
         end else if (cs_hit[i]) begin
            // Upper bits are not stored; a changed code takes effect at once
            clock_sel_q[i] <= (clock_sel_q[i] & ~bus_wr_mask[2:0]) | wmasked[2:0];
         end
      end
      always_ff @(posedge clock or negedge rst_q) begin
         if (!rst_q) begin
            count_en_q[i] <= `EBT_MC_RESET;
         end else if (mc_hit[i] && bus_wr_mask[`EBT_MC_CE_BIT]) begin
            count_en_q[i] <= bus_wdata[`EBT_MC_CE_BIT];
         end
      end
      assign match[i] = count_en_q[i] && tick[i] && cnt_q[i] == cmp[i];
      always_ff @(posedge clock or negedge rst_q) begin
         if (!rst_q) begin
            cnt_q[i] <= '0;
         end else if (!count_en_q[i]) begin
            cnt_q[i] <= '0;
         end else if (match[i]) begin
            cnt_q[i] <= '0;
         end else if (tick[i]) begin
            cnt_q[i] <= cnt_q[i] + 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_q) begin
      if (!rst_q) begin
         inv_en_q <= `EBT_MC_RESET;
      end else if (mc_hit[0] && bus_wr_mask[`EBT_MC_INV_BIT]) begin
         inv_en_q <= bus_wdata[`EBT_MC_INV_BIT];
      end
   end

   // A level write beats a match in the same cycle; code 11 is ignored
   always_ff @(posedge clock or negedge rst_q) begin
      if (!rst_q) begin
         out_q <= 1'b0;
      end else if (lv_wr == 2'h1) begin
         out_q <= 1'b0;
      end else if (lv_wr == 2'h2) begin
         out_q <= 1'b1;
      end else if (match[0] && inv_en_q) begin
         out_q <= !out_q;
      end
   end

   always_ff @(posedge clock or negedge rst_q) begin
      if (!rst_q) begin
         bus_rdata <= 8'h00;
      end else if (bus_rd) begin
         unique case (bus_addr)
            `EBT_ADDR_CS0: bus_rdata <= {5'h00, clock_sel_q[0]};
            `EBT_ADDR_CS1: bus_rdata <= {5'h00, clock_sel_q[1]};
            `EBT_ADDR_CS2: bus_rdata <= {5'h00, clock_sel_q[2]};
            `EBT_ADDR_MC0: bus_rdata <= {count_en_q[0], 5'h00, inv_en_q, 1'b0};
            `EBT_ADDR_MC1: bus_rdata <= {count_en_q[1], 7'h00};
            `EBT_ADDR_MC2: bus_rdata <= {count_en_q[2], 7'h00};
            default: bus_rdata <= 8'h00;
         endcase
      end
   end

   assign count0 = cnt_q[0];
   assign count1 = cnt_q[1];
   assign count2 = cnt_q[2];
   assign timer0_out = out_q;

   property p_cs_byte;
      @(posedge clock) disable iff (!rst_q)
      cs_hit[0] && bus_wr_mask == 8'hff |=> clock_sel_q[0] == $past(bus_wdata[2:0]);
   endproperty
   a_cs_byte: assert property (p_cs_byte) else $error("byte write lost");
   property p_cs_read;
      @(posedge clock) disable iff (!rst_q)
      bus_rd && bus_addr == `EBT_ADDR_CS0 |=> bus_rdata[7:3] == 5'h00;
   endproperty
   a_cs_read: assert property (p_cs_read) else $error("select upper bits set");
   property p_prohib;
      @(posedge clock) disable iff (!rst_q)
      clock_sel_q[0] < 3'h2 && count_en_q[0] && !cs_hit[0] |=> cnt_q[0] == $past(cnt_q[0]);
   endproperty
   a_prohib: assert property (p_prohib) else $error("counting on prohibited code");
   property p_full;
      @(posedge clock) disable iff (!rst_q)
      clock_sel_q[1] == 3'h2 && count_en_q[1] && cnt_q[1] != cmp1
      |=> cnt_q[1] == $past(cnt_q[1]) + 8'h01;
   endproperty
   a_full: assert property (p_full) else $error("full-rate count missed");
   // Judged from the counter, so a broken edge detector cannot satisfy it
   property p_ext_fall;
      @(posedge clock) disable iff (!rst_q)
      clock_sel_q[2] == 3'h0 && count_en_q[2] && cnt_q[2] != cmp2
      && $past(ext_gated) && !ext_gated
      |=> cnt_q[2] == $past(cnt_q[2]) + 8'h01;
   endproperty
   a_ext_fall: assert property (p_ext_fall) else $error("falling edge not counted");
   property p_stop;
      @(posedge clock) disable iff (!rst_q)
      !count_en_q[0] |=> cnt_q[0] == 8'h00;
   endproperty
   a_stop: assert property (p_stop) else $error("stopped counter not clear");
   property p_lv;
      @(posedge clock) disable iff (!rst_q)
      lv_wr == 2'h2 |=> timer0_out ##1 (timer0_out || $past(match[0]) || $past(lv_wr == 2'h1));
   endproperty
   a_lv: assert property (p_lv) else $error("level set failed");
   property p_wo;
      @(posedge clock) disable iff (!rst_q)
      bus_rd && bus_addr == `EBT_ADDR_MC0 |=> bus_rdata[3:2] == 2'h0;
   endproperty
   a_wo: assert property (p_wo) else $error("write-only bits read back");
   property p_toggle;
      @(posedge clock) disable iff (!rst_q)
      match[0] && inv_en_q && lv_wr == 2'h0 |=> timer0_out != $past(timer0_out);
   endproperty
   a_toggle: assert property (p_toggle) else $error("output did not toggle");
   property p_match_clr;
      @(posedge clock) disable iff (!rst_q)
      match[2] |=> cnt_q[2] == 8'h00;
   endproperty
   a_match_clr: assert property (p_match_clr) else $error("match did not clear");

   property p_cov_match;
      @(posedge clock) disable iff (!rst_q)
      match[0] ##[1:300] match[0];
   endproperty
   c_cov_match: cover property (p_cov_match);
   property p_cov_ext;
      @(posedge clock) disable iff (!rst_q)
      clock_sel_q[2] == 3'h1 && match[2];
   endproperty
   c_cov_ext: cover property (p_cov_ext);
   property p_cov_h1;
      @(posedge clock) disable iff (!rst_q)
      clock_sel_q[1] == 3'h7 && match[1];
   endproperty
   c_cov_h1: cover property (p_cov_h1);
endmodule

// [testbench/ebt_timer_ctrl_bench.sv]
`timescale 1ns/1ns
`include "ebt_regs.svh"
module ebt_timer_ctrl_bench;
   import ebt_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] bus_addr = 16'h0000;
   logic bus_wr = 1'b0;
   logic [7:0] bus_wr_mask = 8'h00;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata;
   logic [7:0] cmpv [3] = '{8'h00, 8'h00, 8'h00};
   logic h1 = 1'b0;
   logic ext = 1'b0;
   logic gsel = 1'b0;
   logic glvl = 1'b0;
   logic [7:0] cnt [3];
   logic [2:0] match;
   logic t0out;
   logic [15:0] cs_a [3] = '{`EBT_ADDR_CS0, `EBT_ADDR_CS1, `EBT_ADDR_CS2};
   logic [15:0] mc_a [3] = '{`EBT_ADDR_MC0, `EBT_ADDR_MC1, `EBT_ADDR_MC2};
   int n_mismatch = 0;
   int samples_checked = 0;
   int seed = 32'h6399;
   int cyc = 0;
   int n, e, t, c, b;
   logic [7:0] d, m;
   logic p;
   always #4 clock = ~clock;
   ebt_timer_ctrl dut (.clock(clock), .rstn(rstn), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_wr_mask(bus_wr_mask), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .cmp0(cmpv[0]), .cmp1(cmpv[1]), .cmp2(cmpv[2]),
      .timer_h1_out(h1), .external_count_input(ext), .input_gating_select(gsel),
      .input_gate_level(glvl), .count0(cnt[0]), .count1(cnt[1]), .count2(cnt[2]),
      .match(match), .timer0_out(t0out));
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] mk, input logic [7:0] wd);
      @(posedge clock);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wr_mask <= mk;
      bus_wdata <= wd;
      @(posedge clock);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clock);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clock);
      bus_rd <= 1'b0;
      @(negedge clock);
      chk(bus_rdata, exp);
   endtask
   task automatic wait_m(input int i, input int lim, output int k);
      k = 1;
      @(negedge clock);
      while (match[i] !== 1'b1 && k < lim) begin
         @(negedge clock);
         k++;
      end
   endtask
   // Cycles per count tick; 0 where no internal tick exists
   function automatic int per(input int i, input int s);
      int p2 [3][8] = '{'{0,0,0,1,2,6,8,13}, '{0,0,0,1,4,6,8,0}, '{0,0,0,1,4,6,8,12}};
      if (s < 2 || (i == 1 && s == 7)) begin
         return 0;
      end
      return 1 << p2[i][s];
   endfunction
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (4) @(posedge clock);
      for (t = 0; t < 3; t++) begin
         rd(cs_a[t], 8'h00);
         rd(mc_a[t], 8'h00);
         wr(mc_a[t], 8'h80, 8'h80);
         rd(mc_a[t], 8'h80);
         wr(mc_a[t], 8'h80, 8'h00);
      end
      rd(16'hff00, 8'h00);
      wr(cs_a[0], 8'hff, 8'h07);
      rd(cs_a[0], 8'h07);
      for (n = 0; n < 12; n++) begin
         t = {$random(seed)} % 3;
         d = $random(seed) & 8'h07;
         b = {$random(seed)} % 3;
         p = $random(seed);
         wr(cs_a[t], 8'hff, d);
         rd(cs_a[t], d);
         wr(cs_a[t], 8'h01 << b, {5'h00, {3{p}}});
         m = d;
         m[b] = p;
         rd(cs_a[t], m);
      end
      for (t = 0; t < 3; t++) begin
         for (c = (t == 2) ? 2 : 0; c < 8; c++) begin
            e = per(t, c);
            wr(mc_a[t], 8'hff, 8'h00);
            wr(cs_a[t], 8'hff, c[7:0]);
            cmpv[t] <= (e > 64) ? 8'h00 : 8'h02;
            wr(mc_a[t], 8'hff, 8'h80);
            if (e == 0) begin
               repeat (40) @(negedge clock);
               chk(cnt[t], 8'h00);
            end else begin
               wait_m(t, 4 * e + 20, n);
               wait_m(t, 4 * e + 20, n);
               chk(n, (e > 64) ? e : 3 * e);
            end
         end
         // Stop before reselecting, then check that disabling clears the count
         wr(mc_a[t], 8'hff, 8'h00);
         wr(cs_a[t], 8'hff, 8'h02);
         cmpv[t] <= 8'hff;
         wr(mc_a[t], 8'hff, 8'h80);
         repeat (20) @(negedge clock);
         chk(cnt[t] !== 8'h00, 1'b1);
         wr(mc_a[t], 8'h80, 8'h00);
         // The write edge still counts; the clear lands one cycle later
         repeat (2) @(negedge clock);
         chk(cnt[t], 8'h00);
         repeat (5) @(negedge clock);
         chk(cnt[t], 8'h00);
      end
      // Input left high at the end: rising count is e, falling count e-1
      for (n = 0; n < 5; n++) begin
         t = (n == 0) ? 1 : 2;
         c = (n == 0) ? 7 : n % 2;
         wr(mc_a[t], 8'hff, 8'h00);
         wr(cs_a[t], 8'hff, c[7:0]);
         gsel <= (n > 2);
         glvl <= (n == 4);
         wr(mc_a[t], 8'hff, 8'h80);
         e = 3 + {$random(seed)} % 6;
         for (int k = 0; k < e; k++) begin
            repeat (3) @(posedge clock);
            h1 <= (t == 1);
            ext <= (t == 2);
            repeat (3) @(posedge clock);
            if (k < e - 1) begin
               h1 <= 1'b0;
               ext <= 1'b0;
            end
         end
         repeat (4) @(negedge clock);
         chk(cnt[t], (n == 3) ? 0 : (c == 0) ? e - 1 : e);
         wr(mc_a[t], 8'hff, 8'h00);
         h1 <= 1'b0;
         ext <= 1'b0;
      end
      cmpv[0] <= 8'h03;
      wr(cs_a[0], 8'hff, 8'h02);
      wr(mc_a[0], 8'hff, 8'h02);
      wr(mc_a[0], 8'hff, 8'h06);
      @(negedge clock);
      chk(t0out, 1'b0);
      wr(mc_a[0], 8'hff, 8'h0a);
      @(negedge clock);
      chk(t0out, 1'b1);
      wr(mc_a[0], 8'hff, 8'h0e);
      @(negedge clock);
      chk(t0out, 1'b1);
      rd(mc_a[0], 8'h02);
      wr(mc_a[0], 8'hff, 8'h82);
      for (n = 0; n < 6; n++) begin
         if (n == 4) begin
            wr(mc_a[0], 8'hff, 8'h80);
         end
         wait_m(0, 20, e);
         p = t0out;
         @(negedge clock);
         chk(t0out ^ (n < 4), p);
      end
      finish_test();
   end
endmodule
